// file: hw/emrdi_pkg.sv
// Constants shared by the error message readout and injection path.
// Assumes the error message register layout below is fixed for the whole chip.
package emrdi_pkg;

    // ************************************************************
    // Widths and field layout
    // ************************************************************
    localparam int MSG_W   = 46;
    localparam int INJ_W   = 21;
    localparam int SYN_W   = 16;
    localparam int SYN_LSB = 0;
    localparam int LOC_LSB = 16;
    localparam int LOC_W   = 26;
    localparam int TYPE_LSB = 42;
    localparam int TYPE_W  = 4;
    localparam int INJ_TYPE_HI = 20;
    localparam int INJ_TYPE_LO = 19;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0]        INJ_SINGLE     = 2'h1;
    localparam logic [1:0]        INJ_DOUBLE     = 2'h2;
    localparam logic [TYPE_W-1:0] ERR_SINGLE     = 4'h1;
    localparam logic [TYPE_W-1:0] ERR_DOUBLE_ADJ = 4'h2;
    localparam logic [MSG_W-1:0]  MSG_RST        = 46'h0000_0000_0000;
    localparam logic [INJ_W-1:0]  INJ_RST        = 21'h00_0000;
    localparam logic [LOC_W-1:0]  LOC_CLEAR      = 26'h000_0000;

endpackage

// file: hw/emrdi_sync.sv
// Two flip-flop level synchroniser with a clock enable.
// Assumes d is a level that stays put for at least two destination clocks.
`timescale 1ns/10ps
module emrdi_sync #(
    parameter int Width = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             en,
    input  wire logic [Width-1:0] d,
    output logic      [Width-1:0] q
);
    logic [Width-1:0] meta_q;
    logic [Width-1:0] meta_d;
    logic [Width-1:0] sync_q;
    logic [Width-1:0] sync_d;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (en) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;
endmodule // emrdi_sync

// file: hw/emrdi_top.sv
// Error message readout and fault injection path of the error detection block.
// Assumes core-side inputs are on core_clk and JTAG controls are on tck.
//
// Overview of operation
// - A validated 46-bit error message is copied into the JTAG holding register one cycle later, or waits as pending while the holder is frozen.
// - The JTAG holding register is frozen by the synchronised readout instruction before the JTAG shifter samples it.
// - The core holding register is never written in the cycle the core shifter samples it.
// - Under the readout instruction the JTAG shifter samples the JTAG holding register and shifts it out.
// - Core logic can sample the core holding register into the core shifter and shift it out.
// - A 21-bit injection request register is written only under the fault injection instruction.
// - Each update of the request register loads it into a separate 21-bit working register.
// - The 46-bit message holds type, location and syndrome, with location only for single or adjacent errors.
// - Injection type bits 20:19 give single for 01, double adjacent for 10, and none for 00 or 11.
// - The configuration error output registers whether the 16-bit syndrome is non-zero, on core clocks with clkEn high.
`timescale 1ns/10ps
module emrdi_top #(
    parameter int MsgWidth = emrdi_pkg::MSG_W,
    parameter int InjWidth = emrdi_pkg::INJ_W
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                clkEn,
    input  wire logic [MsgWidth-1:0] errMsgIn,
    input  wire logic                errMsgValid,
    input  wire logic [15:0]         syndrome,
    output logic                     crcError,
    input  wire logic                coreHoldEn,
    input  wire logic                coreSample,
    input  wire logic                coreShiftEn,
    output logic                     coreShiftOut,
    output logic [InjWidth-1:0]      injWorking,
    output logic                     injSingle,
    output logic                     injDouble,
    output logic                     injLoaded,
    input  wire logic                tck,
    input  wire logic                readErrorMessageInstr,
    input  wire logic                faultInjectInstr,
    input  wire logic                jtagCapture,
    input  wire logic                jtagShift,
    input  wire logic                jtagUpdate,
    input  wire logic                tdi,
    output logic                     tdo
);
    if (MsgWidth != emrdi_pkg::MSG_W || InjWidth != emrdi_pkg::INJ_W) begin : g_badWidth
        $error("Field layout only serves the packaged message and injection widths.");
    end

    // ************************************************************
    // Crossings
    // ************************************************************
    logic freezeReq_q;
    logic freezeSync;
    logic ackSync;
    logic injTog_q;
    logic togSync;
    logic tckEn;

    emrdi_sync #(.Width(1)) u_syncFreeze (.clk(core_clk), .rstn(rstn), .en(clkEn),
        .d(freezeReq_q), .q(freezeSync));
    emrdi_sync #(.Width(1)) u_syncAck (.clk(tck), .rstn(rstn), .en(tckEn),
        .d(freezeSync), .q(ackSync));
    emrdi_sync #(.Width(1)) u_syncTog (.clk(core_clk), .rstn(rstn), .en(clkEn),
        .d(injTog_q), .q(togSync));
    emrdi_sync #(.Width(1)) u_syncEn (.clk(tck), .rstn(rstn), .en(1'b1),
        .d(clkEn), .q(tckEn));

    // ************************************************************
    // Core domain: message capture, holding registers, injection
    // ************************************************************
    logic [MsgWidth-1:0] msg_q, msg_d, msgMasked;
    logic [MsgWidth-1:0] jtagHold_q, jtagHold_d;
    logic [MsgWidth-1:0] coreHold_q, coreHold_d;
    logic [MsgWidth-1:0] coreShift_q, coreShift_d;
    logic                jtagPend_q, jtagPend_d;
    logic                corePend_q, corePend_d;
    logic                crcError_q, crcError_d;
    logic [InjWidth-1:0] injReq_q;
    logic [InjWidth-1:0] injWork_q, injWork_d;
    logic                injSingle_q, injSingle_d;
    logic                injDouble_q, injDouble_d;
    logic                injLoad_q, injLoad_d;
    logic                togSeen_q, togSeen_d;
    logic [emrdi_pkg::TYPE_W-1:0] msgType;
    logic                coreBlock;
    logic                togEdge;

    always_comb begin
        // Location is only meaningful for single and adjacent errors.
        msgMasked = errMsgIn;
        msgType   = errMsgIn[emrdi_pkg::TYPE_LSB +: emrdi_pkg::TYPE_W];
        if (msgType != emrdi_pkg::ERR_SINGLE && msgType != emrdi_pkg::ERR_DOUBLE_ADJ) begin
            msgMasked[emrdi_pkg::LOC_LSB +: emrdi_pkg::LOC_W] = emrdi_pkg::LOC_CLEAR;
        end
        msg_d = errMsgValid ? msgMasked : msg_q;

        // A message that lands while the holder is frozen waits as pending; only the last such message is kept.
        jtagHold_d = jtagHold_q;
        jtagPend_d = jtagPend_q;
        if (!freezeSync) begin
            if (errMsgValid) begin
                jtagHold_d = msgMasked;
            end else if (jtagPend_q) begin
                jtagHold_d = msg_q;
            end
            jtagPend_d = 1'b0;
        end else if (errMsgValid) begin
            jtagPend_d = 1'b1;
        end

        coreBlock  = coreHoldEn | coreSample;
        coreHold_d = coreHold_q;
        corePend_d = corePend_q;
        if (!coreBlock) begin
            if (errMsgValid) begin
                coreHold_d = msgMasked;
            end else if (corePend_q) begin
                coreHold_d = msg_q;
            end
            corePend_d = 1'b0;
        end else if (errMsgValid) begin
            corePend_d = 1'b1;
        end

        coreShift_d = coreShift_q;
        if (coreSample) begin
            coreShift_d = coreHold_q;
        end else if (coreShiftEn) begin
            coreShift_d = {1'b0, coreShift_q[MsgWidth-1:1]};
        end

        crcError_d = |syndrome;

        // The request word is stable here: it only changes on a JTAG update under the fault injection instruction, with the toggle.
        togEdge   = togSync ^ togSeen_q;
        togSeen_d = togSync;
        injLoad_d = togEdge;
        injWork_d = togEdge ? injReq_q : injWork_q;
        injSingle_d = injWork_d[emrdi_pkg::INJ_TYPE_HI:emrdi_pkg::INJ_TYPE_LO]
                      == emrdi_pkg::INJ_SINGLE;
        injDouble_d = injWork_d[emrdi_pkg::INJ_TYPE_HI:emrdi_pkg::INJ_TYPE_LO]
                      == emrdi_pkg::INJ_DOUBLE;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            msg_q       <= emrdi_pkg::MSG_RST;
            jtagHold_q  <= emrdi_pkg::MSG_RST;
            coreHold_q  <= emrdi_pkg::MSG_RST;
            coreShift_q <= emrdi_pkg::MSG_RST;
            jtagPend_q  <= 1'b0;
            corePend_q  <= 1'b0;
            crcError_q  <= 1'b0;
            injWork_q   <= emrdi_pkg::INJ_RST;
            injSingle_q <= 1'b0;
            injDouble_q <= 1'b0;
            injLoad_q   <= 1'b0;
            togSeen_q   <= 1'b0;
        end else if (clkEn) begin
            msg_q       <= msg_d;
            jtagHold_q  <= jtagHold_d;
            coreHold_q  <= coreHold_d;
            coreShift_q <= coreShift_d;
            jtagPend_q  <= jtagPend_d;
            corePend_q  <= corePend_d;
            crcError_q  <= crcError_d;
            injWork_q   <= injWork_d;
            injSingle_q <= injSingle_d;
            injDouble_q <= injDouble_d;
            injLoad_q   <= injLoad_d;
            togSeen_q   <= togSeen_d;
        end
    end

    // ************************************************************
    // JTAG domain: readout shifter and injection request
    // ************************************************************
    logic [MsgWidth-1:0] jtagShift_q, jtagShift_d;
    logic [InjWidth-1:0] injShift_q, injShift_d;
    logic [InjWidth-1:0] injReq_d;
    logic                injTog_d;
    logic                freezeReq_d;
    logic                tdo_q, tdo_d;

    always_comb begin
        freezeReq_d = readErrorMessageInstr;
        jtagShift_d = jtagShift_q;
        injShift_d  = injShift_q;
        injReq_d    = injReq_q;
        injTog_d    = injTog_q;
        // Capture waits for the acknowledge, so the holder is frozen while it is read.
        if (readErrorMessageInstr) begin
            if (jtagCapture && ackSync) begin
                jtagShift_d = jtagHold_q;
            end else if (jtagShift) begin
                jtagShift_d = {tdi, jtagShift_q[MsgWidth-1:1]};
            end
        end
        if (faultInjectInstr) begin
            if (jtagShift) begin
                injShift_d = {tdi, injShift_q[InjWidth-1:1]};
            end
            if (jtagUpdate) begin
                injReq_d = injShift_q;
                injTog_d = ~injTog_q;
            end
        end
        tdo_d = readErrorMessageInstr ? jtagShift_d[0] :
                (faultInjectInstr ? injShift_d[0] : 1'b0);
    end

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            jtagShift_q <= emrdi_pkg::MSG_RST;
            injShift_q  <= emrdi_pkg::INJ_RST;
            injReq_q    <= emrdi_pkg::INJ_RST;
            injTog_q    <= 1'b0;
            freezeReq_q <= 1'b0;
            tdo_q       <= 1'b0;
        end else if (tckEn) begin
            jtagShift_q <= jtagShift_d;
            injShift_q  <= injShift_d;
            injReq_q    <= injReq_d;
            injTog_q    <= injTog_d;
            freezeReq_q <= freezeReq_d;
            tdo_q       <= tdo_d;
        end
    end

    assign crcError     = crcError_q;
    assign coreShiftOut = coreShift_q[0];
    assign injWorking   = injWork_q;
    assign injSingle    = injSingle_q;
    assign injDouble    = injDouble_q;
    assign injLoaded    = injLoad_q;
    assign tdo          = tdo_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_holding_copy: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (clkEn && errMsgValid && !freezeSync) |=> (jtagHold_q == $past(msgMasked)))
        else $error("JTAG holding register missed a validated message.");
    a_holding_frozen: assert property (
        @(posedge core_clk) disable iff (!rstn)
        freezeSync |=> $stable(jtagHold_q))
        else $error("JTAG holding register changed while frozen.");
    a_core_noclash: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (coreSample || coreHoldEn) |=> $stable(coreHold_q))
        else $error("Core holding register written while sampled.");
    a_jtag_capture: assert property (
        @(posedge tck) disable iff (!rstn)
        (tckEn && readErrorMessageInstr && jtagCapture && ackSync)
        |=> (jtagShift_q == $past(jtagHold_q)) && (tdo_q == jtagShift_q[0]))
        else $error("JTAG shifter did not capture the holding register.");
    a_core_sample: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (clkEn && coreSample) |=> (coreShift_q == $past(coreHold_q)))
        else $error("Core shifter did not sample the holding register.");
    a_inject_only: assert property (
        @(posedge tck) disable iff (!rstn)
        !(tckEn && faultInjectInstr && jtagUpdate) |=> $stable(injReq_q))
        else $error("Injection request changed without the inject instruction.");
    a_work_load: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (clkEn && togEdge) |=> (injWork_q == $past(injReq_q)) && injLoad_q)
        else $error("Working injection register did not load the request.");
    a_type_decode: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (injSingle_q == (injWork_q[20:19] == 2'h1)) && (injDouble_q == (injWork_q[20:19] == 2'h2)))
        else $error("Injection type decode is wrong.");
    a_crc_level: assert property (
        @(posedge core_clk) disable iff (!rstn)
        clkEn |=> (crcError_q == ($past(syndrome) != 16'h0000)))
        else $error("Configuration error output does not follow the syndrome.");
    a_loc_mask: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (clkEn && errMsgValid && msgType != emrdi_pkg::ERR_SINGLE
         && msgType != emrdi_pkg::ERR_DOUBLE_ADJ) |=> (msg_q[41:16] == 26'h000_0000))
        else $error("Location kept for an error type that has none.");

    c_jtag_read: cover property (@(posedge tck) disable iff (!rstn)
        readErrorMessageInstr && jtagCapture && ackSync);
    c_pend_apply: cover property (@(posedge core_clk) disable iff (!rstn)
        jtagPend_q && !freezeSync && clkEn);
    c_inj_load: cover property (@(posedge core_clk) disable iff (!rstn) injLoad_q && injDouble_q);
    c_crc_rise: cover property (@(posedge core_clk) disable iff (!rstn) $rose(crcError_q));
endmodule // emrdi_top

// file: verification/emrdi_jtag_model.sv
// JTAG controller model: makes tck, drives the test access controls and samples tdo.
// Assumes the device samples every control and tdi on the rising edge of tck.
`timescale 1ns/10ps
module emrdi_jtag_model (
    output logic      tck,
    output logic      readErrorMessageInstr,
    output logic      faultInjectInstr,
    output logic      jtagCapture,
    output logic      jtagShift,
    output logic      jtagUpdate,
    output logic      tdi,
    input  wire logic tdo
);
    logic lastTdo;

    initial begin
        tck = 1'b0;
        {readErrorMessageInstr, faultInjectInstr, jtagCapture, jtagShift, jtagUpdate} = 5'h00;
        tdi = 1'b0;
    end

    // ************************************************************
    // One tck period
    // ************************************************************
    // The clock stands still between calls; an unused tdi toggles so a stale value never passes.
    task automatic tick(input logic r, input logic f, input logic c, input logic s,
                        input logic u, input logic d);
        #16 tck = 1'b1;
        {readErrorMessageInstr, faultInjectInstr, jtagCapture, jtagShift, jtagUpdate} <= {r, f, c, s, u};
        tdi <= d;
        #1 lastTdo = tdo;
        #15 tck = 1'b0;
    endtask

    task automatic idle(input int n, input logic r);
        repeat (n) tick(r, 1'b0, 1'b0, 1'b0, 1'b0, ~tdi);
    endtask

    // ************************************************************
    // Transfers
    // ************************************************************
    // The readout instruction level stays high until the last bit, which keeps the holder frozen.
    task automatic read_msg(output logic [emrdi_pkg::MSG_W-1:0] m);
        idle(8, 1'b1);
        tick(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, ~tdi);
        for (int i = 0; i < emrdi_pkg::MSG_W; i++) begin
            tick(1'b1, 1'b0, 1'b0, (i < emrdi_pkg::MSG_W - 1), 1'b0, ~tdi);
            m[i] = lastTdo;
        end
        idle(1, 1'b0);
    endtask

    task automatic inject(input logic [emrdi_pkg::INJ_W-1:0] v, input logic en);
        for (int i = 0; i < emrdi_pkg::INJ_W; i++) begin
            tick(1'b0, en, 1'b0, 1'b1, 1'b0, v[i]);
        end
        tick(1'b0, en, 1'b0, 1'b0, 1'b1, ~tdi);
        repeat (10) tick(1'b0, en, 1'b0, 1'b0, 1'b0, ~tdi);
    endtask
endmodule // emrdi_jtag_model

// file: verification/tb_top.sv
// Self-checking bench for the error message readout and injection path.
// Assumes the design package is compiled first and the JTAG model drives the tck side.
`timescale 1ns/10ps
module tb_top;
    logic                          core_clk, rstn, clkEn, errMsgValid, crcError;
    logic                          coreHoldEn, coreSample, coreShiftEn, coreShiftOut;
    logic                          injSingle, injDouble, injLoaded, tck, tdi, tdo;
    logic                          readErrorMessageInstr, faultInjectInstr;
    logic                          jtagCapture, jtagShift, jtagUpdate;
    logic [emrdi_pkg::MSG_W-1:0]   errMsgIn, m1, m2, got;
    logic [emrdi_pkg::INJ_W-1:0]   injWorking, v;
    logic [15:0]                   syndrome, s;
    logic [22:0]                   injQ[$];
    logic [22:0]                   injExp;
    int                            n_errors, check_count, seed;

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    emrdi_top dut (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .errMsgIn(errMsgIn),
        .errMsgValid(errMsgValid), .syndrome(syndrome), .crcError(crcError),
        .coreHoldEn(coreHoldEn), .coreSample(coreSample), .coreShiftEn(coreShiftEn),
        .coreShiftOut(coreShiftOut), .injWorking(injWorking), .injSingle(injSingle),
        .injDouble(injDouble), .injLoaded(injLoaded), .tck(tck),
        .readErrorMessageInstr(readErrorMessageInstr), .faultInjectInstr(faultInjectInstr),
        .jtagCapture(jtagCapture), .jtagShift(jtagShift), .jtagUpdate(jtagUpdate),
        .tdi(tdi), .tdo(tdo));

    emrdi_jtag_model partner (.tck(tck), .readErrorMessageInstr(readErrorMessageInstr),
        .faultInjectInstr(faultInjectInstr), .jtagCapture(jtagCapture),
        .jtagShift(jtagShift), .jtagUpdate(jtagUpdate), .tdi(tdi), .tdo(tdo));

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic check(input string what, input logic [45:0] exp, input logic [45:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Location survives only for single and adjacent error types.
    function automatic logic [45:0] expect_msg(input logic [45:0] m);
        if (m[45:42] == emrdi_pkg::ERR_SINGLE || m[45:42] == emrdi_pkg::ERR_DOUBLE_ADJ) return m;
        return {m[45:42], emrdi_pkg::LOC_CLEAR, m[15:0]};
    endfunction

    // ************************************************************
    // Core side drivers
    // ************************************************************
    task automatic send(input logic [45:0] m);
        @(posedge core_clk);
        errMsgIn <= m;
        errMsgValid <= 1'b1;
        @(posedge core_clk);
        errMsgValid <= 1'b0;
    endtask

    // A message offered in the sample cycle must not reach the shifter.
    task automatic core_read(output logic [45:0] q, input logic [45:0] other, input logic hit);
        @(posedge core_clk) coreHoldEn <= 1'b1;
        @(posedge core_clk);
        coreSample <= 1'b1;
        errMsgValid <= hit;
        errMsgIn <= other;
        for (int i = 0; i < emrdi_pkg::MSG_W; i++) begin
            @(posedge core_clk);
            errMsgValid <= 1'b0;
            coreSample <= 1'b0;
            coreShiftEn <= (i < emrdi_pkg::MSG_W - 1);
            coreHoldEn <= (i < emrdi_pkg::MSG_W - 1);
            #1 q[i] = coreShiftOut;
        end
    endtask

    // ************************************************************
    // Injection watcher
    // ************************************************************
    always @(posedge core_clk) begin
        #1;
        if (injLoaded === 1'b1) begin
            if (injQ.size() == 0) check("injLoaded unexpected", 46'h0, 46'h1);
            else begin
                injExp = injQ.pop_front();
                check("injWorking", injExp[20:0], injWorking);
                check("injSingle injDouble", injExp[22:21], {injSingle, injDouble});
            end
        end
    end

    initial begin
        #100000;
        n_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        seed = 32'h54e9;
        {rstn, errMsgValid, coreHoldEn, coreSample, coreShiftEn} = 5'h00;
        clkEn = 1'b1;
        errMsgIn = emrdi_pkg::MSG_RST;
        syndrome = 16'h0000;
        fork
            repeat (20) @(posedge core_clk);
            partner.idle(6, 1'b0);
        join
        rstn <= 1'b1;
        @(posedge core_clk);
        #1 check("outputs after reset", 46'h0, {crcError, coreShiftOut, injWorking, injLoaded, tdo});
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            s = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0001 : (k == 2) ? 16'h8000 : $random(seed);
            @(posedge core_clk) syndrome <= s;
            @(posedge core_clk);
            #1 check("crcError", (s != 16'h0000), crcError);
        end
        // With the clock enable low the output must hold although the syndrome moves.
        @(posedge core_clk) clkEn <= 1'b0;
        syndrome <= ~s;
        repeat (3) @(posedge core_clk);
        #1 check("crcError frozen", (s != 16'h0000), crcError);
        clkEn <= 1'b1;
        @(posedge core_clk);
        #1 check("crcError resumed", (~s != 16'h0000), crcError);
        $display("test crc error done");
        m1 = {emrdi_pkg::ERR_SINGLE, 42'({$random(seed), $random(seed)})};
        send(m1);
        partner.read_msg(got);
        check("jtag readout", expect_msg(m1), got);
        m2 = {4'h3, 42'({$random(seed), $random(seed)})};
        partner.idle(8, 1'b1);
        send(m2);
        partner.read_msg(got);
        check("jtag frozen readout", expect_msg(m1), got);
        partner.idle(8, 1'b0);
        partner.read_msg(got);
        check("jtag pending readout", expect_msg(m2), got);
        $display("test jtag readout done");
        m1 = {emrdi_pkg::ERR_DOUBLE_ADJ, 42'({$random(seed), $random(seed)})};
        m2 = {emrdi_pkg::ERR_SINGLE, 42'({$random(seed), $random(seed)})};
        send(m1);
        core_read(got, m2, 1'b1);
        check("core sample cycle readout", expect_msg(m1), got);
        core_read(got, m2, 1'b0);
        check("core later readout", expect_msg(m2), got);
        $display("test core readout done");
        for (int t = 0; t < 4; t++) begin
            v = $random(seed);
            v[20:19] = t[1:0];
            injQ.push_back({(t == 1), (t == 2), v});
            partner.inject(v, 1'b1);
            check("injection loads pending", 46'h0, injQ.size());
        end
        partner.inject(~v, 1'b0);
        check("injection without instruction", v, injWorking);
        $display("test injection done");
        end_sim();
    end
endmodule // tb_top
